/* File: design/adc_cfg_pkg.sv */
// Package with register map, field layout and state types of the converter configuration block
package adc_cfg_pkg;

	// Register addresses (6-bit address field of the command byte)
	localparam logic [5:0] ADDR_STATUS     = 6'h00;
	localparam logic [5:0] ADDR_CONV_MODE  = 6'h01;
	localparam logic [5:0] ADDR_PORT_MODE  = 6'h02;
	localparam logic [5:0] ADDR_IDENT      = 6'h07;
	localparam logic [5:0] ADDR_CHAN_BASE  = 6'h10;
	localparam logic [5:0] ADDR_SETUP_BASE = 6'h20;
	localparam logic [5:0] ADDR_ZERO_BASE  = 6'h30;
	localparam logic [5:0] ADDR_FULL_BASE  = 6'h38;

	// Command byte fields
	localparam int CMD_WEN_BIT = 7;
	localparam int CMD_RD_BIT  = 6;

	// Reset values
	localparam logic [15:0] CONV_MODE_RST  = 16'ha000;
	localparam logic [15:0] PORT_MODE_RST  = 16'h0000;
	localparam logic [15:0] CHAN0_RST      = 16'h8001;
	localparam logic [15:0] CHAN_RST       = 16'h0001;
	localparam logic [15:0] SETUP_RST      = 16'h1320;
	localparam logic [23:0] ZERO_SCALE_RST = 24'h800000;

	// Writable bit masks, reserved bits read as zero
	localparam logic [15:0] CONV_MODE_MASK = 16'he77c;
	localparam logic [15:0] PORT_MODE_MASK = 16'h19ed;
	localparam logic [15:0] CHAN_MASK      = 16'hf3ff;
	localparam logic [15:0] SETUP_MASK     = 16'h1fb0;

	// Converter mode fields
	localparam int REF_EN_BIT     = 15;
	localparam int CONCEAL_BIT    = 14;
	localparam int SETTLE_BIT     = 13;
	localparam int MODE_LSB       = 4;
	localparam int CLK_SRC_LSB    = 2;
	// Serial port mode fields
	localparam int SHORT_WORD_BIT = 0;
	localparam int STREAM_BIT     = 7;
	// Channel fields
	localparam int CH_EN_BIT      = 15;
	localparam int CH_SETUP_LSB   = 12;
	localparam int CH_POS_LSB     = 5;
	localparam int CH_NEG_LSB     = 0;
	// Setup configuration field: analog input buffer enables
	localparam int AIN_BUF_LSB    = 8;

	// Conversion mode codes
	localparam logic [2:0] MODE_CONT     = 3'h0;
	localparam logic [2:0] MODE_SINGLE   = 3'h1;
	localparam logic [2:0] MODE_STANDBY  = 3'h2;
	localparam logic [2:0] MODE_INT_ZERO = 3'h4;
	localparam logic [2:0] MODE_SYS_ZERO = 3'h6;
	localparam logic [2:0] MODE_SYS_FULL = 3'h7;

	// Consecutive high data bits that reset the register contents
	localparam logic [6:0] SOFT_RESET_ONES = 7'h40;

	typedef enum logic [2:0] {
		SER_CMD = 3'b001,
		SER_WR  = 3'b010,
		SER_RD  = 3'b100
	} ser_state_t;

	// Routing of the active channel toward the analog core
	typedef struct packed {
		logic [3:0]  chan;
		logic [4:0]  pos;
		logic [4:0]  neg;
		logic [2:0]  setup;
		logic [1:0]  buf_en;
		logic [23:0] gain;
		logic [23:0] offs;
	} route_t;

	typedef struct packed {
		logic [1:0]        sclk_sync;
		logic [1:0]        cs_n_sync;
		logic [1:0]        din_sync;
		logic              sclk_prev;
		ser_state_t        ser;
		logic [4:0]        bit_cnt;
		logic [4:0]        len;
		logic [5:0]        addr;
		logic [23:0]       sh;
		logic [6:0]        ones;
		logic              dout;
		logic [15:0]       conv_mode;
		logic [15:0]       port_mode;
		logic [15:0][15:0] chan;
		logic [7:0][15:0]  setup;
		logic [7:0][23:0]  zero;
		logic [7:0][23:0]  full;
		logic [3:0]        cur;
		route_t            route;
	} cfg_state_t;

	// Data length in bits of the register at an address
	function automatic logic [4:0] reg_len(input logic [5:0] a);
		if (a == ADDR_STATUS)
			return 5'h08;
		else if (a >= ADDR_ZERO_BASE)
			return 5'h18;
		else
			return 5'h10;
	endfunction

endpackage

/* File: design/adc_channel_setup_config.sv */
// Register file, calibration coefficient update and channel sequencer of the converter
`timescale 1ns/1ps
module adc_channel_setup_config #(
	parameter logic [23:0] FULL_SCALE_TRIM = 24'h5a5a50,  // Per-part trim, value arbitrary
	parameter logic [15:0] IDENT_CODE      = 16'h1230     // Arbitrary identity value
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	input  wire logic        sclk_i,
	input  wire logic        cs_n_i,
	input  wire logic        din_i,
	output logic             dout_o,
	input  wire logic        conv_done_i,
	input  wire logic        cal_done_i,
	input  wire logic [23:0] cal_result_i,
	output logic [3:0]       chan_o,
	output logic [4:0]       ain_pos_o,
	output logic [4:0]       ain_neg_o,
	output logic [2:0]       setup_o,
	output logic [1:0]       ain_buf_en_o,
	output logic [23:0]      gain_coef_o,
	output logic [23:0]      offset_coef_o,
	output logic [2:0]       conv_mode_o,
	output logic [1:0]       clock_src_o,
	output logic             ref_en_o,
	output logic             delay_conceal_o,
	output logic             one_cycle_settle_o,
	output logic             short_word_length_o,
	output logic             streaming_readback_o
);
	adc_cfg_pkg::cfg_state_t st_r;
	adc_cfg_pkg::cfg_state_t st_nxt;
	logic [15:0]             enable_vec;
	logic [3:0]              step_next;
	logic                    step_any;

	// Default register contents after power-on or serial reset
	function automatic adc_cfg_pkg::cfg_state_t load_defaults(input adc_cfg_pkg::cfg_state_t s);
		adc_cfg_pkg::cfg_state_t d;
		d           = s;
		d.conv_mode = adc_cfg_pkg::CONV_MODE_RST;
		d.port_mode = adc_cfg_pkg::PORT_MODE_RST;
		for (int i = 0; i < 16; i++)
			d.chan[i] = (i == 0) ? adc_cfg_pkg::CHAN0_RST : adc_cfg_pkg::CHAN_RST;
		for (int i = 0; i < 8; i++) begin
			d.setup[i] = adc_cfg_pkg::SETUP_RST;
			d.zero[i]  = adc_cfg_pkg::ZERO_SCALE_RST;
			d.full[i]  = FULL_SCALE_TRIM;
		end
		d.cur = '0;
		return d;
	endfunction

	// Readback value of a register, left unaligned in the low bits
	function automatic logic [23:0] read_reg(input adc_cfg_pkg::cfg_state_t s,
	                                         input logic [5:0] a);
		logic [23:0] v;
		v = '0;
		if (a == adc_cfg_pkg::ADDR_STATUS)
			v = {20'h00000, s.cur};
		else if (a == adc_cfg_pkg::ADDR_CONV_MODE)
			v = {8'h00, s.conv_mode};
		else if (a == adc_cfg_pkg::ADDR_PORT_MODE)
			v = {8'h00, s.port_mode};
		else if (a == adc_cfg_pkg::ADDR_IDENT)
			v = {8'h00, IDENT_CODE};
		else if (a[5:4] == 2'h1)
			v = {8'h00, s.chan[a[3:0]]};
		else if (a[5:3] == 3'h4)
			v = {8'h00, s.setup[a[2:0]]};
		else if (a[5:3] == 3'h6)
			v = s.zero[a[2:0]];
		else if (a[5:3] == 3'h7)
			v = s.full[a[2:0]];
		return v;
	endfunction

	// Enable bits of all channels feed the next-channel finder
	always_comb begin
		for (int i = 0; i < 16; i++)
			enable_vec[i] = st_r.chan[i][adc_cfg_pkg::CH_EN_BIT];
	end

	chan_step #(
		.NCH (16)
	) chan_step_inst (
		.enable_i (enable_vec),
		.cur_i    (st_r.cur),
		.next_o   (step_next),
		.any_o    (step_any)
	);

	// Next state: serial port, register writes, calibration and sequencing
	always_comb begin
		logic        rise;
		logic        fall;
		logic        bit_in;
		logic [7:0]  cmd;
		logic [23:0] wdata;
		logic [5:0]  a;
		logic [2:0]  mode;
		logic [2:0]  cal_setup;
		logic        wr_commit;
		logic        restart;
		logic [15:0] ch;
		st_nxt    = st_r;
		rise      = 1'b0;
		fall      = 1'b0;
		bit_in    = 1'b0;
		ch        = '0;
		wr_commit = 1'b0;
		restart   = 1'b0;
		a         = st_r.addr;
		cmd       = '0;
		wdata     = '0;
		mode      = st_r.conv_mode[adc_cfg_pkg::MODE_LSB +: 3];
		cal_setup = st_r.chan[st_r.cur][adc_cfg_pkg::CH_SETUP_LSB +: 3];

		// Two-stage synchronisers on the serial pins
		st_nxt.sclk_sync = {st_r.sclk_sync[0], sclk_i};
		st_nxt.cs_n_sync = {st_r.cs_n_sync[0], cs_n_i};
		st_nxt.din_sync  = {st_r.din_sync[0], din_i};
		st_nxt.sclk_prev = st_r.sclk_sync[1];
		bit_in = st_r.din_sync[1];
		rise   = st_r.sclk_sync[1] && !st_r.sclk_prev && !st_r.cs_n_sync[1];
		fall   = !st_r.sclk_sync[1] && st_r.sclk_prev && !st_r.cs_n_sync[1];

		// Deselect returns the port to waiting for a command
		if (st_r.cs_n_sync[1]) begin
			st_nxt.ser     = adc_cfg_pkg::SER_CMD;
			st_nxt.bit_cnt = '0;
		end else if (rise) begin
			st_nxt.sh      = {st_r.sh[22:0], bit_in};
			st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
			st_nxt.ones    = bit_in ? st_r.ones + 7'h01 : 7'h00;
			unique case (st_r.ser)
				adc_cfg_pkg::SER_CMD: begin
					if (st_r.bit_cnt == 5'h07) begin
						cmd            = {st_r.sh[6:0], bit_in};
						a              = cmd[5:0];
						st_nxt.addr    = a;
						st_nxt.len     = adc_cfg_pkg::reg_len(a);
						st_nxt.bit_cnt = '0;
						if (cmd[adc_cfg_pkg::CMD_WEN_BIT])
							st_nxt.ser = adc_cfg_pkg::SER_CMD;              // Not a command
						else if (cmd[adc_cfg_pkg::CMD_RD_BIT]) begin
							st_nxt.ser = adc_cfg_pkg::SER_RD;
							st_nxt.sh  = read_reg(st_r, a) << (5'h18 - adc_cfg_pkg::reg_len(a));
						end else
							st_nxt.ser = adc_cfg_pkg::SER_WR;
					end
				end
				adc_cfg_pkg::SER_WR: begin
					if (st_r.bit_cnt == st_r.len - 5'h01) begin
						wdata          = {st_r.sh[22:0], bit_in};
						wr_commit      = 1'b1;
						st_nxt.ser     = adc_cfg_pkg::SER_CMD;
						st_nxt.bit_cnt = '0;
					end
				end
				adc_cfg_pkg::SER_RD: begin
					st_nxt.sh = st_r.sh;                                    // Shifted on fall
					if (st_r.bit_cnt == st_r.len - 5'h01) begin
						st_nxt.ser     = adc_cfg_pkg::SER_CMD;
						st_nxt.bit_cnt = '0;
					end
				end
			endcase
		end else if (fall && st_r.ser == adc_cfg_pkg::SER_RD) begin
			st_nxt.dout = st_r.sh[23];
			st_nxt.sh   = {st_r.sh[22:0], 1'b0};
		end

		// Calibration result replaces the coefficient of the active setup
		if (cal_done_i) begin
			if (mode == adc_cfg_pkg::MODE_INT_ZERO || mode == adc_cfg_pkg::MODE_SYS_ZERO)
				st_nxt.zero[cal_setup] = cal_result_i;
			else if (mode == adc_cfg_pkg::MODE_SYS_FULL)
				st_nxt.full[cal_setup] = cal_result_i;
			st_nxt.conv_mode[adc_cfg_pkg::MODE_LSB +: 3] = adc_cfg_pkg::MODE_STANDBY;
		end

		// Sequencer advances on each finished conversion in continuous mode; single mode drops to standby
		if (conv_done_i && step_any) begin
			if (mode == adc_cfg_pkg::MODE_CONT)
				st_nxt.cur = step_next;
			else if (mode == adc_cfg_pkg::MODE_SINGLE)
				st_nxt.conv_mode[adc_cfg_pkg::MODE_LSB +: 3] = adc_cfg_pkg::MODE_STANDBY;
		end

		// Host write; a write in the same cycle overrides a calibration result
		if (wr_commit) begin
			if (a == adc_cfg_pkg::ADDR_CONV_MODE) begin
				st_nxt.conv_mode = wdata[15:0] & adc_cfg_pkg::CONV_MODE_MASK;
				restart          = 1'b1;
			end else if (a == adc_cfg_pkg::ADDR_PORT_MODE)
				st_nxt.port_mode = wdata[15:0] & adc_cfg_pkg::PORT_MODE_MASK;
			else if (a[5:4] == 2'h1) begin
				st_nxt.chan[a[3:0]] = wdata[15:0] & adc_cfg_pkg::CHAN_MASK;
				restart             = 1'b1;
			end else if (a[5:3] == 3'h4)
				st_nxt.setup[a[2:0]] = wdata[15:0] & adc_cfg_pkg::SETUP_MASK;
			else if (a[5:3] == 3'h6)
				st_nxt.zero[a[2:0]] = wdata;
			else if (a[5:3] == 3'h7)
				st_nxt.full[a[2:0]] = wdata;
		end

		// A rewrite of the mode or a channel restarts the sequence from channel 0
		if (restart)
			st_nxt.cur = '0;

		// 64 consecutive high data bits restore every register
		if (st_nxt.ones >= adc_cfg_pkg::SOFT_RESET_ONES) begin
			st_nxt      = load_defaults(st_nxt);
			st_nxt.ones = '0;
			st_nxt.ser  = adc_cfg_pkg::SER_CMD;
		end

		// Route the active channel and its setup toward the analog core
		ch                  = st_nxt.chan[st_nxt.cur];
		st_nxt.route.chan   = st_nxt.cur;
		st_nxt.route.pos    = ch[adc_cfg_pkg::CH_POS_LSB +: 5];
		st_nxt.route.neg    = ch[adc_cfg_pkg::CH_NEG_LSB +: 5];
		st_nxt.route.setup  = ch[adc_cfg_pkg::CH_SETUP_LSB +: 3];
		st_nxt.route.buf_en = st_nxt.setup[st_nxt.route.setup][adc_cfg_pkg::AIN_BUF_LSB +: 2];
		st_nxt.route.gain   = st_nxt.full[st_nxt.route.setup];
		st_nxt.route.offs   = st_nxt.zero[st_nxt.route.setup];
	end

	// State register; the power-on image is built from constants only
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_r              <= load_defaults('0);
			st_r.ser          <= adc_cfg_pkg::SER_CMD;
			st_r.sclk_sync    <= 2'h3;
			st_r.cs_n_sync    <= 2'h3;
			st_r.sclk_prev    <= 1'b1;
			st_r.route.pos    <= 5'h00;
			st_r.route.neg    <= 5'h01;
			st_r.route.buf_en <= adc_cfg_pkg::SETUP_RST[adc_cfg_pkg::AIN_BUF_LSB +: 2];
			st_r.route.gain   <= FULL_SCALE_TRIM;
			st_r.route.offs   <= adc_cfg_pkg::ZERO_SCALE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs taken straight from state flip-flops
	assign dout_o               = st_r.dout;
	assign chan_o               = st_r.route.chan;
	assign ain_pos_o            = st_r.route.pos;
	assign ain_neg_o            = st_r.route.neg;
	assign setup_o              = st_r.route.setup;
	assign ain_buf_en_o         = st_r.route.buf_en;
	assign gain_coef_o          = st_r.route.gain;
	assign offset_coef_o        = st_r.route.offs;
	assign conv_mode_o          = st_r.conv_mode[adc_cfg_pkg::MODE_LSB +: 3];
	assign clock_src_o          = st_r.conv_mode[adc_cfg_pkg::CLK_SRC_LSB +: 2];
	assign ref_en_o             = st_r.conv_mode[adc_cfg_pkg::REF_EN_BIT];
	assign delay_conceal_o      = st_r.conv_mode[adc_cfg_pkg::CONCEAL_BIT];
	assign one_cycle_settle_o   = st_r.conv_mode[adc_cfg_pkg::SETTLE_BIT];
	assign short_word_length_o  = st_r.port_mode[adc_cfg_pkg::SHORT_WORD_BIT];
	assign streaming_readback_o = st_r.port_mode[adc_cfg_pkg::STREAM_BIT];
endmodule

/* File: design/chan_step.sv */
// Finder of the next enabled channel after the current one, wrapping around
`timescale 1ns/1ps
module chan_step #(
	parameter int NCH = 16
) (
	input  wire logic [NCH-1:0]         enable_i,
	input  wire logic [$clog2(NCH)-1:0] cur_i,
	output logic      [$clog2(NCH)-1:0] next_o,
	output logic                        any_o
);
	localparam int W = $clog2(NCH);

	// Scan upward from the current slot; the first hit wins, skipping disabled slots
	always_comb begin
		logic [W-1:0] idx;
		logic         found;
		idx    = '0;
		found  = 1'b0;
		next_o = cur_i;
		for (int i = 1; i <= NCH; i++) begin
			idx = W'((int'(cur_i) + i) % NCH);
			if (!found && enable_i[idx]) begin
				next_o = idx;
				found  = 1'b1;
			end
		end
		any_o = |enable_i;
	end
endmodule

/* File: dv/adc_cfg_chk.sv */
// Port checker of the converter configuration block, bound to its top module
`timescale 1ns/1ps
module adc_cfg_chk #(
	parameter logic [23:0] FULL_SCALE_TRIM = 24'h5a5a50
) (
	input wire logic        ref_clk_i,
	input wire logic        rst_i,
	input wire logic        cs_n_i,
	input wire logic        conv_done_i,
	input wire logic        cal_done_i,
	input wire logic [23:0] cal_result_i,
	input wire logic [3:0]  chan_o,
	input wire logic [23:0] gain_coef_o,
	input wire logic [23:0] offset_coef_o,
	input wire logic [2:0]  conv_mode_o,
	input wire logic [1:0]  clock_src_o,
	input wire logic        ref_en_o,
	input wire logic        short_word_length_o
);
	logic [23:0] cal_val_r;
	logic        quiet;
	logic        cal_mode;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Keeps the last result offered with a calibration pulse
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i)
			cal_val_r <= 24'h000000;
		else if (cal_done_i)
			cal_val_r <= cal_result_i;
	end
	// No host frame, no core event; calibration codes 4, 6 and 7
	assign quiet    = cs_n_i && !cal_done_i && !conv_done_i;
	assign cal_mode = conv_mode_o[2] && (conv_mode_o != 3'h5);
	reset_values_a: assert property ($fell(rst_i) |-> ref_en_o && conv_mode_o == 3'h0
		&& chan_o == 4'h0 && offset_coef_o == 24'h800000 && gain_coef_o == FULL_SCALE_TRIM)
		else $error("wrong outputs after reset");
	trim_pattern_a: assert property ($fell(rst_i) |-> gain_coef_o[23:20] == 4'h5
		&& gain_coef_o[3:0] == 4'h0) else $error("full-scale default pattern wrong");
	zero_cal_a: assert property (cal_done_i && conv_mode_o inside {3'h4, 3'h6}
		|-> ##[1:3] offset_coef_o == cal_val_r) else $error("zero-scale result not taken");
	full_cal_a: assert property (cal_done_i && conv_mode_o == 3'h7
		|-> ##[1:3] gain_coef_o == cal_val_r) else $error("full-scale result not taken");
	cal_standby_a: assert property (cal_done_i && cal_mode
		|-> ##[1:3] conv_mode_o == 3'h2) else $error("calibration did not end in standby");
	single_standby_a: assert property (conv_done_i && conv_mode_o == 3'h1
		|-> ##[1:3] conv_mode_o == 3'h2) else $error("single conversion did not stop");
	mode_hold_a: assert property (cs_n_i [*4] |=> $stable(clock_src_o) && $stable(ref_en_o)
		&& $stable(short_word_length_o)) else $error("mode field changed without a write");
	route_hold_a: assert property (quiet [*4] |=> $stable(chan_o) && $stable(gain_coef_o)
		&& $stable(offset_coef_o)) else $error("routing changed without a cause");
endmodule

bind adc_channel_setup_config adc_cfg_chk #(.FULL_SCALE_TRIM(FULL_SCALE_TRIM)) adc_cfg_chk_inst (
	.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .conv_done_i(conv_done_i),
	.cal_done_i(cal_done_i), .cal_result_i(cal_result_i), .chan_o(chan_o),
	.gain_coef_o(gain_coef_o), .offset_coef_o(offset_coef_o), .conv_mode_o(conv_mode_o),
	.clock_src_o(clock_src_o), .ref_en_o(ref_en_o), .short_word_length_o(short_word_length_o)
);

/* File: dv/adc_channel_setup_config_bench.sv */
// Self-checking bench of the converter configuration block
`timescale 1ns/1ps
module adc_channel_setup_config_bench;
	localparam logic [23:0] TRIM = 24'h5a5a50;  // Per-part trim, value arbitrary
	localparam logic [2:0] CAL_MODE [3] = '{3'h4, 3'h6, 3'h7};
	logic        ref_clk_i, rst_i, sclk_i, cs_n_i, din_i, dout_o, conv_done_i, cal_done_i;
	logic [23:0] cal_result_i, gain_coef_o, offset_coef_o;
	logic [3:0]  chan_o;
	logic [4:0]  ain_pos_o, ain_neg_o;
	logic [2:0]  setup_o, conv_mode_o;
	logic [1:0]  ain_buf_en_o, clock_src_o;
	logic        ref_en_o, delay_conceal_o, one_cycle_settle_o;
	logic        short_word_length_o, streaming_readback_o;
	int          miscompares, samples_checked;
	adc_channel_setup_config #(.FULL_SCALE_TRIM(TRIM)) adc_channel_setup_config_inst (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .din_i(din_i),
		.dout_o(dout_o), .conv_done_i(conv_done_i), .cal_done_i(cal_done_i),
		.cal_result_i(cal_result_i), .chan_o(chan_o), .ain_pos_o(ain_pos_o), .ain_neg_o(ain_neg_o),
		.setup_o(setup_o), .ain_buf_en_o(ain_buf_en_o), .gain_coef_o(gain_coef_o),
		.offset_coef_o(offset_coef_o), .conv_mode_o(conv_mode_o), .clock_src_o(clock_src_o),
		.ref_en_o(ref_en_o), .delay_conceal_o(delay_conceal_o),
		.one_cycle_settle_o(one_cycle_settle_o), .short_word_length_o(short_word_length_o),
		.streaming_readback_o(streaming_readback_o));
	adc_host_model adc_host_model_inst (.ref_clk_i(ref_clk_i), .dout_i(dout_o), .sclk_o(sclk_i),
		.cs_n_o(cs_n_i), .din_o(din_i));
	// 50 MHz clock
	initial begin
		ref_clk_i = 1'b0;
		forever #10 ref_clk_i = ~ref_clk_i;
	end
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [23:0] d);
		logic [23:0] r;
		adc_host_model_inst.xfer({2'b00, a}, d, r);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
		logic [23:0] r;
		adc_host_model_inst.xfer({2'b01, a}, 24'h000000, r);
		check($sformatf("register %h", a), r, exp);
	endtask
	// One-cycle completion pulse from the analog core
	task automatic pulse_done(input logic cal, input logic [23:0] res);
		@(posedge ref_clk_i);
		cal_done_i   <= cal;
		conv_done_i  <= ~cal;
		cal_result_i <= res;
		@(posedge ref_clk_i);
		cal_done_i  <= 1'b0;
		conv_done_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
	endtask
	task automatic print_verdict();
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Hang guard, far above the expected run length
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		miscompares++;
		print_verdict();
	end
	// Main sequence
	initial begin
		rst_i = 1'b1;
		conv_done_i = 1'b0;
		cal_done_i = 1'b0;
		cal_result_i = 24'h000000;
		miscompares = 0;
		samples_checked = 0;
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge ref_clk_i);
		check("trim nibbles", 24'({gain_coef_o[23:20], gain_coef_o[3:0]}), 24'h000050);
		rd_chk(adc_cfg_pkg::ADDR_CONV_MODE, 24'h00a000);
		rd_chk(adc_cfg_pkg::ADDR_PORT_MODE, 24'h000000);
		rd_chk(adc_cfg_pkg::ADDR_ZERO_BASE, 24'h800000);
		rd_chk(adc_cfg_pkg::ADDR_FULL_BASE, TRIM);
		rd_chk(adc_cfg_pkg::ADDR_CHAN_BASE, 24'h008001);
		rd_chk(adc_cfg_pkg::ADDR_SETUP_BASE, 24'h001320);
		rd_chk(adc_cfg_pkg::ADDR_IDENT, 24'h001230);
		// Mode fields, reserved bits and the single conversion
		wr(adc_cfg_pkg::ADDR_CONV_MODE, 24'h00ff8f);
		rd_chk(adc_cfg_pkg::ADDR_CONV_MODE, 24'h00e70c);
		check("mode outs", 24'({ref_en_o, delay_conceal_o, one_cycle_settle_o, clock_src_o,
			conv_mode_o}), 24'h0000f8);
		wr(adc_cfg_pkg::ADDR_CONV_MODE, 24'h002014);
		check("mode outs", 24'({ref_en_o, delay_conceal_o, one_cycle_settle_o, clock_src_o,
			conv_mode_o}), 24'h000029);
		pulse_done(1'b0, 24'h000000);
		check("single stop", 24'(conv_mode_o), 24'h000002);
		wr(adc_cfg_pkg::ADDR_PORT_MODE, 24'h00ff7f);
		rd_chk(adc_cfg_pkg::ADDR_PORT_MODE, 24'h00196d);
		check("port outs", 24'({streaming_readback_o, short_word_length_o}), 24'h1);
		wr(adc_cfg_pkg::ADDR_PORT_MODE, 24'h000080);
		check("port outs", 24'({streaming_readback_o, short_word_length_o}), 24'h2);
		wr(adc_cfg_pkg::ADDR_PORT_MODE, 24'h000000);
		wr(6'h0b, 24'h00ffff);
		rd_chk(6'h0b, 24'h000000);
		// Coefficients by host write and by each calibration code
		wr(adc_cfg_pkg::ADDR_ZERO_BASE, 24'h123456);
		rd_chk(adc_cfg_pkg::ADDR_ZERO_BASE, 24'h123456);
		wr(adc_cfg_pkg::ADDR_FULL_BASE, 24'habcdef);
		rd_chk(adc_cfg_pkg::ADDR_FULL_BASE, 24'habcdef);
		check("gain out", gain_coef_o, 24'habcdef);
		for (int k = 0; k < 3; k++) begin
			wr(adc_cfg_pkg::ADDR_CONV_MODE, 24'({CAL_MODE[k], 4'h0}));
			pulse_done(1'b1, 24'h0f1e20 + 24'(k));
			check("cal standby", 24'(conv_mode_o), 24'h000002);
			rd_chk((k == 2) ? adc_cfg_pkg::ADDR_FULL_BASE : adc_cfg_pkg::ADDR_ZERO_BASE,
				24'h0f1e20 + 24'(k));
		end
		// Sequencer over channels 0, 3 and 7 with their own setups
		wr(adc_cfg_pkg::ADDR_CHAN_BASE + 6'h03, 24'h0090b0);
		wr(adc_cfg_pkg::ADDR_CHAN_BASE + 6'h07, 24'h00a200);
		wr(adc_cfg_pkg::ADDR_SETUP_BASE + 6'h01, 24'h001000);
		wr(adc_cfg_pkg::ADDR_ZERO_BASE + 6'h01, 24'h654321);
		wr(adc_cfg_pkg::ADDR_FULL_BASE + 6'h01, 24'h13579b);
		wr(adc_cfg_pkg::ADDR_CONV_MODE, 24'h008000);
		check("chan", 24'(chan_o), 24'h000000);
		pulse_done(1'b0, 24'h000000);
		check("chan", 24'(chan_o), 24'h000003);
		check("route", 24'({setup_o, ain_pos_o, ain_neg_o, ain_buf_en_o}), 24'h0012c0);
		check("gain out", gain_coef_o, 24'h13579b);
		check("offset out", offset_coef_o, 24'h654321);
		rd_chk(adc_cfg_pkg::ADDR_STATUS, 24'h000003);
		pulse_done(1'b0, 24'h000000);
		check("chan", 24'(chan_o), 24'h000007);
		check("route", 24'({setup_o, ain_pos_o, ain_neg_o, ain_buf_en_o}), 24'h002803);
		check("gain out", gain_coef_o, TRIM);
		pulse_done(1'b0, 24'h000000);
		check("chan", 24'(chan_o), 24'h000000);
		// Serial reset restores register contents
		adc_host_model_inst.serial_reset();
		rd_chk(adc_cfg_pkg::ADDR_CONV_MODE, 24'h00a000);
		rd_chk(adc_cfg_pkg::ADDR_CHAN_BASE + 6'h03, 24'h000001);
		rd_chk(adc_cfg_pkg::ADDR_ZERO_BASE + 6'h01, 24'h800000);
		print_verdict();
	end
endmodule

/* File: dv/adc_host_model.sv */
// Host controller model driving the serial register port
`timescale 1ns/1ps
module adc_host_model (
	input  wire logic ref_clk_i,
	input  wire logic dout_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      din_o
);
	// Serial clock idles high and stands still between frames
	initial begin
		sclk_o = 1'b1;
		cs_n_o = 1'b1;
		din_o  = 1'b0;
	end
	// One bit: data set with the fall, read data taken just before the rise
	task automatic shift_bit(input logic b, output logic r);
		sclk_o <= 1'b0;
		din_o  <= b;
		repeat (5) @(posedge ref_clk_i);
		r = dout_i;
		sclk_o <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
	endtask
	// Command byte, then data as long as the addressed register
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wdata, output logic [23:0] rdata);
		int   n;
		logic r;
		n = (cmd[5:0] == 6'h00) ? 8 : (cmd[5:0] >= 6'h30) ? 24 : 16;
		rdata = 24'h000000;
		@(posedge ref_clk_i);
		cs_n_o <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		for (int i = 7; i >= 0; i--)
			shift_bit(cmd[i], r);
		for (int i = n - 1; i >= 0; i--) begin
			shift_bit(wdata[i], r);
			rdata = {rdata[22:0], r};
		end
		cs_n_o <= 1'b1;
		din_o  <= ~din_o;
		repeat (5) @(posedge ref_clk_i);
	endtask
	// Sixty-four high data bits inside one frame
	task automatic serial_reset();
		logic r;
		@(posedge ref_clk_i);
		cs_n_o <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		for (int i = 0; i < 64; i++)
			shift_bit(1'b1, r);
		cs_n_o <= 1'b1;
		din_o  <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
	endtask
endmodule
